// ### rtl/optical_mgmt_pkg.sv
// constants of the optical module management logic
// assumes one 40 mhz clock and an axi4-lite port
`default_nettype none
package optical_mgmt_pkg;
  // clock rate and laser switching bounds
  localparam int CLK_KHZ = 40_000;
  localparam int T_OFF_MAX_MS = 100;
  localparam int T_ON_MAX_MS = 100;
  localparam int LASER_OFF_MAX_CYCLES = T_OFF_MAX_MS * CLK_KHZ;
  localparam int LASER_ON_MAX_CYCLES = T_ON_MAX_MS * CLK_KHZ;
  // default settle counts, inside the bound
  localparam int LASER_SETTLE_DEFAULT = LASER_ON_MAX_CYCLES / 2;
  localparam int READY_SETTLE_DEFAULT = 40_000;
  localparam int TIMER_W = 22;
  // axi4-lite shape and answers
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register byte offsets
  localparam logic [7:0] REG_READING_BASE = 8'h00;
  localparam logic [7:0] REG_ALARM_LIM_BASE = 8'h20;
  localparam logic [7:0] REG_WARN_LIM_BASE = 8'h40;
  localparam logic [7:0] REG_PIN_STATUS = 8'h60;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h64;
  localparam logic [7:0] REG_IRQ_MASK = 8'h68;
  // irq status bits and mask reset
  localparam int IRQ_HOST_WRITE = 0;
  localparam int IRQ_PD_RESET = 1;
  localparam int IRQ_ALARM = 2;
  localparam int IRQ_TXDIS_CHANGE = 3;
  localparam int IRQ_W = 4;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  // monitored: temperature, bias, tx power, rx power, supply
  localparam int NUM_MON = 5;
  // two-wire memory layout
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam int MEM_AW = 6;
  localparam logic [5:0] MEM_ALARM_HI = 6'h0a;
  localparam logic [5:0] MEM_ALARM_LO = 6'h0b;
  localparam logic [5:0] MEM_WARN_HI = 6'h0c;
  localparam logic [5:0] MEM_WARN_LO = 6'h0d;
  localparam logic [5:0] MEM_STATUS = 6'h0e;
  localparam logic [5:0] MEM_FIRST_RW = 6'h10;
  localparam int USER_BYTES = 48;
  // pin positions in the synchroniser
  localparam int SY_DESEL = 0;
  localparam int SY_TXDIS = 1;
  localparam int SY_PD = 2;
  localparam int SY_SCL = 3;
  localparam int SY_SDA = 4;
  localparam int SY_SIGDET = 5;
  localparam int SY_W = 6;
  // two-wire slave states
  typedef enum logic [3:0] {
    TW_IDLE = 4'h0,
    TW_ADDR = 4'h1,
    TW_ACK_ADDR = 4'h2,
    TW_WORD = 4'h3,
    TW_ACK_WORD = 4'h4,
    TW_WRDATA = 4'h5,
    TW_ACK_WR = 4'h6,
    TW_RDDATA = 4'h7,
    TW_RDACK = 4'h8,
    TW_WAIT_STOP = 4'h9
  } tw_state_t;
endpackage
`default_nettype wire

// ### rtl/pin_sync.sv
// two-flop synchroniser for async pin levels
// assumes pins slower than aclk
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw pins and synchronised levels
  input wire logic [W-1:0] pins,
  output logic [W-1:0] levels
);
  typedef struct packed {
    logic [W-1:0] meta; // first stage
    logic [W-1:0] stable; // second stage
  } sync_state_t;
  sync_state_t s;
  sync_state_t next_s;

  // two flops before any reader
  always_comb
  begin
    next_s = s;
    next_s.meta = pins;
    next_s.stable = s.meta;
  end

  // synchronous active-low reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign levels = s.stable;
endmodule
`default_nettype wire

// ### rtl/settle_timer.sv
// settle counter: done rises a fixed count after hold drops
// assumes restart and hold are on aclk
`default_nettype none
module settle_timer #(
  parameter int unsigned CYCLES = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control and result
  input wire logic restart,
  input wire logic hold,
  output logic done
);
  import optical_mgmt_pkg::*;
  typedef struct packed {
    logic [TIMER_W-1:0] count; // cycles since hold dropped
    logic done; // count reached
  } timer_state_t;
  timer_state_t s;
  timer_state_t next_s;

  // count up while free, clear on hold or restart
  always_comb
  begin
    next_s = s;
    if (restart || hold)
      next_s = '0;
    else if (s.count >= TIMER_W'(CYCLES - 1))
      next_s.done = 1'b1;
    else
      next_s.count = s.count + TIMER_W'(1);
  end

  // synchronous active-low reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign done = s.done;
endmodule
`default_nettype wire

// ### rtl/optical_module_mgmt_control.sv
// optical transceiver module management and control
// assumes async host pins and scl/sda, firmware on axi4-lite
// writing readings and limits; all timing on aclk
// Contract
// RQ1 - respond on two-wire only while deselect low
// RQ2 - deselected: never acknowledge nor drive data line
// RQ3 - attention low on condition, readable over bus
// RQ4 - transmit disable switches laser off
// RQ5 - laser off and on within 100 ms
// RQ6 - presence output grounded inside the module
// RQ7 - drive receive loss-of-signal indicator output
// RQ8 - loss indicator low normal, high when lost
// RQ9 - power-down high holds low-power standby
// RQ10 - power-down falling edge fully resets module; code resets only the two-wire slave, user bytes and settle timers
// RQ11 - works without any reference clock
// RQ12 - host makes serial clock, module never does
// RQ13 - write on rising edges, unprotected bytes only
// RQ14 - launch read bits on falling edges
// RQ15 - host marks start and stop on data
// RQ16 - byte memory, random and sequential access
// RQ17 - live monitor readings readable over bus
// RQ18 - alarm and warning flags outside limits
`default_nettype none
module optical_module_mgmt_control #(
  parameter int unsigned LASER_SETTLE_CYCLES = optical_mgmt_pkg::LASER_SETTLE_DEFAULT,
  parameter int unsigned READY_SETTLE_CYCLES = optical_mgmt_pkg::READY_SETTLE_DEFAULT
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [optical_mgmt_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [optical_mgmt_pkg::AXI_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read channels
  input wire logic [optical_mgmt_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [optical_mgmt_pkg::AXI_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // interrupt to firmware
  output logic irq,
  // host control pins
  input wire logic module_deselect,
  input wire logic transmit_disable,
  input wire logic power_down,
  // two-wire pins, data line open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // host status pins
  output logic attention_n,
  output logic module_absent,
  output logic not_ready_output,
  output logic rx_signal_lost,
  // optics side
  input wire logic rx_signal_detect,
  output logic laser_enable
);
  import optical_mgmt_pkg::*;

  typedef struct packed {
    // axi write and read channel state
    logic aw_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [AXI_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [AXI_DATA_W-1:0] r_data;
    logic [1:0] r_resp;
    // firmware registers
    logic [NUM_MON-1:0][15:0] reading;
    logic [NUM_MON-1:0][31:0] alarm_lim;
    logic [NUM_MON-1:0][31:0] warn_lim;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    // previous pin levels
    logic scl_q;
    logic sda_q;
    logic pd_q;
    logic txd_q;
    // two-wire slave
    tw_state_t tw_state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [MEM_AW-1:0] ptr;
    logic is_read;
    logic sda_drive;
    logic [USER_BYTES-1:0][7:0] mem;
    // monitor flags and pin state
    logic [NUM_MON-1:0] alarm_hi;
    logic [NUM_MON-1:0] alarm_lo;
    logic [NUM_MON-1:0] warn_hi;
    logic [NUM_MON-1:0] warn_lo;
    logic attention;
    logic sig_ok;
    logic laser_on;
    logic ready;
  } state_t;
  state_t s;
  state_t next_s;

  logic [SY_W-1:0] sy; // synchronised pins
  logic desel, txd, pd, scl, sda, sigdet;
  logic laser_done, ready_done; // settle timers
  logic scl_rise, scl_fall, tw_start, tw_stop, pd_fall;
  logic [NUM_MON-1:0] cmp_ahi, cmp_alo, cmp_whi, cmp_wlo;

  // all pins two-flop synchronised; scl only sampled
  pin_sync #(.W(SY_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins({rx_signal_detect, sda_in, scl_in, power_down, transmit_disable, module_deselect}),
    .levels(sy)
  ); // [RQ12]
  assign desel = sy[SY_DESEL];
  assign txd = sy[SY_TXDIS];
  assign pd = sy[SY_PD];
  assign scl = sy[SY_SCL];
  assign sda = sy[SY_SDA];
  assign sigdet = sy[SY_SIGDET];

  // edges and bus conditions on synced levels
  assign scl_rise = scl && !s.scl_q;
  assign scl_fall = !scl && s.scl_q;
  assign tw_start = scl && s.scl_q && s.sda_q && !sda; // [RQ15]
  assign tw_stop = scl && s.scl_q && !s.sda_q && sda; // [RQ15]
  assign pd_fall = s.pd_q && !pd;

  // laser turn-on delay; turn-off is immediate
  settle_timer #(.CYCLES(LASER_SETTLE_CYCLES)) u_laser_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(pd_fall),
    .hold(txd || pd),
    .done(laser_done)
  ); // [RQ5]

  // not-ready window after reset or standby
  settle_timer #(.CYCLES(READY_SETTLE_CYCLES)) u_ready_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(pd_fall),
    .hold(pd),
    .done(ready_done)
  ); // [RQ10]

  // limit comparators per monitored quantity
  genvar gi;
  generate
    for (gi = 0; gi < NUM_MON; gi++)
    begin : g_mon
      assign cmp_ahi[gi] = s.reading[gi] > s.alarm_lim[gi][31:16]; // [RQ18]
      assign cmp_alo[gi] = s.reading[gi] < s.alarm_lim[gi][15:0]; // [RQ18]
      assign cmp_whi[gi] = s.reading[gi] > s.warn_lim[gi][31:16]; // [RQ18]
      assign cmp_wlo[gi] = s.reading[gi] < s.warn_lim[gi][15:0]; // [RQ18]
    end
  endgenerate

  // byte the host reads at an address
  function automatic logic [7:0] mem_byte(input state_t st, input logic [MEM_AW-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a >= MEM_FIRST_RW)
      v = st.mem[MEM_AW'(a - MEM_FIRST_RW)];
    else if (a < MEM_ALARM_HI)
      v = a[0] ? st.reading[a[3:1]][7:0] : st.reading[a[3:1]][15:8]; // [RQ17]
    else if (a == MEM_ALARM_HI)
      v = 8'(st.alarm_hi); // [RQ18]
    else if (a == MEM_ALARM_LO)
      v = 8'(st.alarm_lo);
    else if (a == MEM_WARN_HI)
      v = 8'(st.warn_hi);
    else if (a == MEM_WARN_LO)
      v = 8'(st.warn_lo);
    else if (a == MEM_STATUS)
      v = {4'h0, st.attention, !st.ready, !st.laser_on, !st.sig_ok}; // [RQ3]
    return v;
  endfunction

  // merge written bytes under strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    logic [31:0] v;
    v = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        v[8*b +: 8] = d[8*b +: 8];
    return v;
  endfunction

  // next state of the whole block
  always_comb
  begin
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic [5:0] widx;
    logic [5:0] ridx;
    logic [7:0] nb;
    irq_set = '0;
    irq_clr = '0;
    widx = s.aw_addr[7:2];
    ridx = araddr[7:2];
    nb = 8'h00;
    next_s = s;
    next_s.scl_q = scl;
    next_s.sda_q = sda;
    next_s.pd_q = pd;
    next_s.txd_q = txd;
    // live flags from readings against limits
    next_s.alarm_hi = cmp_ahi; // [RQ18]
    next_s.alarm_lo = cmp_alo;
    next_s.warn_hi = cmp_whi;
    next_s.warn_lo = cmp_wlo;
    next_s.attention = |{cmp_ahi, cmp_alo, cmp_whi, cmp_wlo}; // [RQ3]
    next_s.sig_ok = sigdet; // [RQ7]
    next_s.laser_on = laser_done && !txd && !pd; // [RQ4] [RQ9]
    next_s.ready = ready_done && !pd; // [RQ9]
    if (|(cmp_ahi & ~s.alarm_hi) || |(cmp_alo & ~s.alarm_lo))
      irq_set[IRQ_ALARM] = 1'b1;
    if (txd != s.txd_q)
      irq_set[IRQ_TXDIS_CHANGE] = 1'b1;

    // axi write: address and data in any order, answer after both
    if (awvalid && awready)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_s.w_held = 1'b1;
      next_s.w_data = wdata;
      next_s.w_strb = wstrb;
    end
    if (s.aw_held && s.w_held && !s.b_valid)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.b_valid = 1'b1;
      next_s.b_resp = RESP_OKAY;
      if (widx < 6'(NUM_MON))
        next_s.reading[widx[2:0]] = 16'(merge(32'(s.reading[widx[2:0]]), s.w_data, s.w_strb));
      else if (widx >= REG_ALARM_LIM_BASE[7:2] && widx < REG_ALARM_LIM_BASE[7:2] + 6'(NUM_MON))
        next_s.alarm_lim[widx[2:0]] = merge(s.alarm_lim[widx[2:0]], s.w_data, s.w_strb);
      else if (widx >= REG_WARN_LIM_BASE[7:2] && widx < REG_WARN_LIM_BASE[7:2] + 6'(NUM_MON))
        next_s.warn_lim[widx[2:0]] = merge(s.warn_lim[widx[2:0]], s.w_data, s.w_strb);
      else if (widx == REG_IRQ_STATUS[7:2])
        irq_clr = s.w_strb[0] ? s.w_data[IRQ_W-1:0] : '0;
      else if (widx == REG_IRQ_MASK[7:2])
      begin
        if (s.w_strb[0])
          next_s.irq_mask = s.w_data[IRQ_W-1:0];
      end
      else
        next_s.b_resp = RESP_SLVERR;
    end
    else if (s.b_valid && bready)
      next_s.b_valid = 1'b0;

    // axi read: one answer per taken address
    if (arvalid && arready)
    begin
      next_s.r_valid = 1'b1;
      next_s.r_resp = RESP_OKAY;
      next_s.r_data = '0;
      if (ridx < 6'(NUM_MON))
        next_s.r_data = 32'(s.reading[ridx[2:0]]);
      else if (ridx >= REG_ALARM_LIM_BASE[7:2] && ridx < REG_ALARM_LIM_BASE[7:2] + 6'(NUM_MON))
        next_s.r_data = s.alarm_lim[ridx[2:0]];
      else if (ridx >= REG_WARN_LIM_BASE[7:2] && ridx < REG_WARN_LIM_BASE[7:2] + 6'(NUM_MON))
        next_s.r_data = s.warn_lim[ridx[2:0]];
      else if (ridx == REG_PIN_STATUS[7:2])
        next_s.r_data = {20'h00000, s.tw_state, 1'b0, s.attention, !s.sig_ok, !s.ready,
                         s.laser_on, pd, txd, desel};
      else if (ridx == REG_IRQ_STATUS[7:2])
        next_s.r_data = 32'(s.irq_status);
      else if (ridx == REG_IRQ_MASK[7:2])
        next_s.r_data = 32'(s.irq_mask);
      else
        next_s.r_resp = RESP_SLVERR;
    end
    else if (s.r_valid && rready)
      next_s.r_valid = 1'b0;

    // two-wire slave: sample on scl rise, launch on fall
    if (pd || desel)
    begin
      // standby or deselected: no ack, line released
      next_s.tw_state = TW_IDLE; // [RQ1] [RQ9]
      next_s.sda_drive = 1'b0; // [RQ2]
    end
    else if (tw_start)
    begin
      // (repeated) start: expect device address
      next_s.tw_state = TW_ADDR; // [RQ15]
      next_s.bit_cnt = 4'h0;
      next_s.sda_drive = 1'b0;
    end
    else if (tw_stop)
    begin
      next_s.tw_state = TW_IDLE; // [RQ15]
      next_s.sda_drive = 1'b0;
    end
    else
    begin
      case (s.tw_state)
        TW_ADDR, TW_WORD, TW_WRDATA:
        begin
          if (scl_rise)
          begin
            next_s.shift = {s.shift[6:0], sda};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            if (s.tw_state == TW_WRDATA && s.bit_cnt == 4'h7)
            begin
              // eighth bit: store unless write-protected
              if (s.ptr >= MEM_FIRST_RW)
              begin
                next_s.mem[MEM_AW'(s.ptr - MEM_FIRST_RW)] = {s.shift[6:0], sda}; // [RQ13]
                irq_set[IRQ_HOST_WRITE] = 1'b1;
              end
              next_s.ptr = s.ptr + MEM_AW'(1); // [RQ16]
            end
          end
          else if (scl_fall && s.bit_cnt == 4'h8)
          begin
            next_s.bit_cnt = 4'h0;
            if (s.tw_state == TW_ADDR)
            begin
              if (s.shift[7:1] == DEV_ADDR)
              begin
                next_s.is_read = s.shift[0];
                next_s.sda_drive = 1'b1;
                next_s.tw_state = TW_ACK_ADDR;
              end
              else
                next_s.tw_state = TW_WAIT_STOP;
            end
            else if (s.tw_state == TW_WORD)
            begin
              next_s.ptr = s.shift[MEM_AW-1:0]; // [RQ16]
              next_s.sda_drive = 1'b1;
              next_s.tw_state = TW_ACK_WORD;
            end
            else
            begin
              next_s.sda_drive = 1'b1;
              next_s.tw_state = TW_ACK_WR;
            end
          end
        end
        TW_ACK_ADDR:
        begin
          if (scl_fall)
          begin
            if (s.is_read)
            begin
              // read starts at the pointer
              nb = mem_byte(s, s.ptr);
              next_s.shift = nb;
              next_s.sda_drive = !nb[7]; // [RQ14]
              next_s.tw_state = TW_RDDATA;
            end
            else
            begin
              next_s.sda_drive = 1'b0;
              next_s.tw_state = TW_WORD;
            end
          end
        end
        TW_ACK_WORD, TW_ACK_WR:
        begin
          if (scl_fall)
          begin
            next_s.sda_drive = 1'b0;
            next_s.tw_state = TW_WRDATA;
          end
        end
        TW_RDDATA:
        begin
          if (scl_rise)
            next_s.bit_cnt = s.bit_cnt + 4'h1;
          else if (scl_fall && s.bit_cnt == 4'h8)
          begin
            // byte out: release for host ack
            next_s.bit_cnt = 4'h0;
            next_s.sda_drive = 1'b0;
            next_s.ptr = s.ptr + MEM_AW'(1); // [RQ16]
            next_s.tw_state = TW_RDACK;
          end
          else if (scl_fall)
          begin
            next_s.shift = {s.shift[6:0], 1'b0};
            next_s.sda_drive = !s.shift[6]; // [RQ14]
          end
        end
        TW_RDACK:
        begin
          if (scl_rise)
          begin
            if (sda)
              next_s.tw_state = TW_WAIT_STOP;
            else
              next_s.bit_cnt = 4'h8;
          end
          else if (scl_fall && s.bit_cnt == 4'h8)
          begin
            // acked: sequential read of next byte
            nb = mem_byte(s, s.ptr);
            next_s.bit_cnt = 4'h0;
            next_s.shift = nb;
            next_s.sda_drive = !nb[7]; // [RQ14] [RQ16]
            next_s.tw_state = TW_RDDATA;
          end
        end
        TW_IDLE, TW_WAIT_STOP:
          next_s.sda_drive = 1'b0;
        default:
        begin
          next_s.tw_state = TW_IDLE;
          next_s.sda_drive = 1'b0;
        end
      endcase
    end

    // falling power-down: clear two-wire slave and user bytes, restart settle timers
    if (pd_fall)
    begin
      next_s.tw_state = TW_IDLE; // [RQ10]
      next_s.bit_cnt = 4'h0;
      next_s.shift = 8'h00;
      next_s.ptr = '0;
      next_s.is_read = 1'b0;
      next_s.sda_drive = 1'b0;
      next_s.mem = '0;
      irq_set[IRQ_PD_RESET] = 1'b1;
    end

    // sticky status: set wins over same-cycle clear
    next_s.irq_status = (s.irq_status & ~irq_clr) | irq_set;
  end

  // one register for all state; no reference clock used
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0; // [RQ11]
      s.irq_mask <= IRQ_MASK_RESET;
    end
    else
      s <= next_s;
  end

  // axi handshakes: one write and one read in flight
  assign awready = !s.aw_held && !s.b_valid;
  assign wready = !s.w_held && !s.b_valid;
  assign bvalid = s.b_valid;
  assign bresp = s.b_resp;
  assign arready = !s.r_valid;
  assign rvalid = s.r_valid;
  assign rdata = s.r_data;
  assign rresp = s.r_resp;
  assign irq = |(s.irq_status & s.irq_mask);

  // host pins
  assign sda_out = 1'b0;
  assign sda_oe = s.sda_drive; // [RQ2]
  assign attention_n = !s.attention; // [RQ3]
  assign module_absent = 1'b0; // [RQ6]
  assign not_ready_output = !s.ready;
  assign rx_signal_lost = !s.sig_ok; // [RQ7] [RQ8]
  assign laser_enable = s.laser_on; // [RQ4] [RQ5]
endmodule
`default_nettype wire

// ### tb/optical_mgmt_chk.sv
// pin assertions for the management block
// bound into the block top, all on aclk
`default_nettype none
module optical_mgmt_chk #(
  parameter int unsigned LASER_SETTLE_CYCLES = 20
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // host pins and optics
  input wire logic module_deselect,
  input wire logic transmit_disable,
  input wire logic power_down,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic module_absent,
  input wire logic not_ready_output,
  input wire logic rx_signal_lost,
  input wire logic rx_signal_detect,
  input wire logic laser_enable
);
  // turn-on bound: settle count plus sync margin
  localparam int ON_MAX = LASER_SETTLE_CYCLES + 12;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_absent_low: assert property (!module_absent)
    else $error("presence pin high");
  chk_los_level: assert property (
    $stable(rx_signal_detect) [*6] |-> rx_signal_lost == !rx_signal_detect)
    else $error("loss indicator wrong");
  chk_txdis_off: assert property (transmit_disable [*6] |-> !laser_enable)
    else $error("laser on while disabled");
  chk_laser_on: assert property (
    $fell(transmit_disable) |-> ##[1:ON_MAX] (laser_enable || transmit_disable || power_down))
    else $error("laser late");
  chk_pd_laser: assert property (power_down [*6] |-> !laser_enable)
    else $error("laser on in standby");
  chk_pd_quiet: assert property (power_down [*6] |-> not_ready_output && !sda_oe)
    else $error("active in standby");
  chk_desel_quiet: assert property (module_deselect [*6] |-> !sda_oe)
    else $error("driven while deselected");
  chk_launch_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("launch with clock high");
  cover property ($rose(sda_oe));
  cover property ($rose(laser_enable));
  cover property ($fell(rx_signal_lost));
endmodule
bind optical_module_mgmt_control optical_mgmt_chk #(
  .LASER_SETTLE_CYCLES(LASER_SETTLE_CYCLES)
) u_chk (.*);
`default_nettype wire

// ### tb/optical_host_model.sv
// host model mastering the two-wire bus, 200 ns per bit
// callers start frames just after an aclk edge
`default_nettype none
module optical_host_model (
  // serial clock and data drive, data released high
  output var logic scl,
  output var logic sda_drv,
  // resolved data line
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus: clock stands high, data released
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // (repeated) start: data falls while clock high
  task automatic start_c;
    #57 sda_drv = 1'b1;
    #50 scl = 1'b1;
    #100 sda_drv = 1'b0;
    #100 scl = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop_c;
    #50 sda_drv = 1'b0;
    #50 scl = 1'b1;
    #100 sda_drv = 1'b1;
    #100;
  endtask
  // nine bits msb first, sampled late in each high phase
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--)
    begin
      #50 sda_drv = d[i];
      #50 scl = 1'b1;
      #90 q[i] = sda_line;
      #10 scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### tb/optical_module_mgmt_control_tb.sv
// self-checking bench for the optical module management block
// host model on the two-wire pins, bench on axi and pins
`default_nettype none
module optical_module_mgmt_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import optical_mgmt_pkg::*;
  // stimulus and host lines
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, scl, host_sda;
  logic module_deselect, transmit_disable, power_down, rx_signal_detect;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  // design outputs
  logic awready, wready, bvalid, arready, rvalid, irq, sda_out, sda_oe;
  logic attention_n, module_absent, not_ready_output, rx_signal_lost, laser_enable;
  logic [1:0] bresp, rresp;
  int fails = 0;
  int tests_run = 0;
  // data line pulled up, low while either side pulls
  wire logic sda_w = host_sda & ~(sda_oe & ~sda_out);
  optical_module_mgmt_control #(
    .LASER_SETTLE_CYCLES(20),
    .READY_SETTLE_CYCLES(10)
  ) u_dut (
    .scl_in(scl),
    .sda_in(sda_w),
    .*
  );
  optical_host_model u_host (.scl(scl), .sda_drv(host_sda), .sda_line(sda_w));
  // 40 mhz clock
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic print_verdict;
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // one comparison
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // a spent wait ends the run
  task automatic give_up(input int n);
    fails += (n >= 50);
    if (n >= 50)
      print_verdict();
  endtask
  // axi write (w high) or read; address and data on the same edge, checks response and read data
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e);
    int n;
    @(posedge aclk);
    {awaddr, araddr, wdata, wstrb} <= {a, a, d, 4'hf};
    {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
    for (n = 0; n < 50 && !(bvalid || rvalid); n++)
    begin
      @(posedge aclk);
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
      arvalid <= arvalid & ~arready;
    end
    give_up(n);
    {bready, rready} <= 2'h0;
    cmp("resp", e, w ? bresp : rresp);
    if (!w)
      cmp("rdata", d, rdata);
  endtask
  // two-wire byte write; ek is the expected address ack
  task automatic twi_wr(input logic [5:0] w, input logic [7:0] d, input logic ek);
    logic [8:0] q;
    @(posedge aclk);
    u_host.start_c();
    u_host.xfer({DEV_ADDR, 2'h1}, q);
    cmp("ack", ek, q[0]);
    if (!ek)
    begin
      u_host.xfer({2'h0, w, 1'b1}, q);
      u_host.xfer({d, 1'b1}, q);
    end
    u_host.stop_c();
    @(posedge aclk);
  endtask
  // random read plus one sequential byte
  task automatic twi_rd(input logic [5:0] w, output logic [15:0] v);
    logic [8:0] q;
    @(posedge aclk);
    u_host.start_c();
    u_host.xfer({DEV_ADDR, 2'h1}, q);
    u_host.xfer({2'h0, w, 1'b1}, q);
    u_host.start_c();
    u_host.xfer({DEV_ADDR, 2'h3}, q);
    u_host.xfer(9'h1fe, q);
    v[15:8] = q[8:1];
    u_host.xfer(9'h1ff, q);
    v[7:0] = q[8:1];
    u_host.stop_c();
    @(posedge aclk);
  endtask
  // limits, readings, attention, irq, bad addresses
  task automatic s_alarm;
    axi(1'b1, REG_WARN_LIM_BASE, 32'hffff0000, RESP_OKAY);
    axi(1'b1, REG_ALARM_LIM_BASE, 32'h10000000, RESP_OKAY);
    axi(1'b1, REG_READING_BASE, 32'h1234, RESP_OKAY);
    axi(1'b0, REG_READING_BASE, 32'h1234, RESP_OKAY);
    cmp("attention", 32'h0, attention_n);
    axi(1'b1, REG_IRQ_MASK, 32'h4, RESP_OKAY);
    cmp("irq", 32'h1, irq);
    axi(1'b1, REG_READING_BASE, 32'h0800, RESP_OKAY);
    axi(1'b1, REG_IRQ_STATUS, 32'hf, RESP_OKAY);
    axi(1'b0, REG_IRQ_STATUS, 32'h0, RESP_OKAY);
    cmp("attention", 32'h1, attention_n);
    axi(1'b1, REG_PIN_STATUS, 32'h0, RESP_SLVERR);
    axi(1'b0, 8'hfc, 32'h0, RESP_SLVERR);
  endtask
  // laser switching and loss indicator
  task automatic s_laser;
    repeat (30) @(posedge aclk);
    cmp("laser", 32'h1, laser_enable);
    cmp("los", 32'h0, rx_signal_lost);
    {transmit_disable, rx_signal_detect} <= 2'h2;
    repeat (8) @(posedge aclk);
    cmp("laser", 32'h0, laser_enable);
    cmp("los", 32'h1, rx_signal_lost);
    {transmit_disable, rx_signal_detect} <= 2'h1;
    repeat (30) @(posedge aclk);
    cmp("laser", 32'h1, laser_enable);
    axi(1'b0, REG_IRQ_STATUS, 32'h8, RESP_OKAY);
    axi(1'b1, REG_IRQ_STATUS, 32'h8, RESP_OKAY);
  endtask
  // two-wire writes, reads and deselect
  task automatic s_twi;
    logic [15:0] v;
    twi_wr(6'h10, 8'ha5, 1'b0);
    twi_wr(6'h00, 8'hff, 1'b0);
    twi_rd(6'h00, v);
    cmp("bytes", 32'h0800, v);
    module_deselect <= 1'b1;
    twi_wr(6'h11, 8'h5a, 1'b1);
    module_deselect <= 1'b0;
    twi_rd(6'h10, v);
    cmp("bytes", 32'ha500, v);
    axi(1'b0, REG_IRQ_STATUS, 32'h1, RESP_OKAY);
  endtask
  // standby and reset on leaving it
  task automatic s_pd;
    logic [15:0] v;
    power_down <= 1'b1;
    repeat (8) @(posedge aclk);
    cmp("not ready", 32'h1, not_ready_output);
    power_down <= 1'b0;
    repeat (40) @(posedge aclk);
    cmp("not ready", 32'h0, not_ready_output);
    twi_rd(6'h10, v);
    cmp("bytes", 32'h0, v);
    axi(1'b0, REG_IRQ_STATUS, 32'h3, RESP_OKAY);
  endtask
  // reset, scenarios, verdict
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
    {module_deselect, transmit_disable, power_down, rx_signal_detect} = 4'h1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    s_alarm();
    s_laser();
    s_twi();
    s_pd();
    print_verdict();
  end
endmodule
`default_nettype wire
